// >>> pkg/chopper_pkg.sv
// Purpose: Shared constants and types for the chopper current control block
// Assumes: 200 MHz reference clock, 32-bit AHB-Lite register bus
// Notes:   Timing counts are derived from times in their own units

package chopper_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Clocking
  localparam int REF_CLK_HZ   = 200_000_000;
  localparam int OSC_HZ       = 4_000_000;
  localparam int OSC_DIV      = REF_CLK_HZ / OSC_HZ;
  localparam int OSC_DIV_W    = $clog2(OSC_DIV);

  //////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int OFF_DEFAULT_US   = 25;
  localparam int OFF_DEFAULT_TICK = OFF_DEFAULT_US * (OSC_HZ / 1_000_000);
  localparam int BLANK_NS         = 1000;
  localparam int BLANK_CYC        = (BLANK_NS * (REF_CLK_HZ / 1_000_000)
                                     + 999) / 1000;
  localparam int SHORT_DLY_NS     = 100;
  localparam int SHORT_DLY_CYC    = (SHORT_DLY_NS * (REF_CLK_HZ / 1_000_000))
                                    / 1000;
  localparam int FAST_NUM         = 301;
  localparam int FAST_DEN         = 1000;
  localparam int OFF_W            = 16;

  //////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam logic [7:0] REG_OFF_TIME   = 8'h00;
  localparam logic [7:0] REG_STATUS     = 8'h04;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK   = 8'h0C;

  // Status fields
  localparam int ST_MIXED_LSB  = 0;
  localparam int ST_OFF_LSB    = 2;
  localparam int ST_SHORT_BIT  = 4;
  localparam int ST_OUT_EN_BIT = 5;
  localparam int ST_SHUT_BIT   = 6;
  localparam int ST_REG_BIT    = 7;

  // Interrupt fields
  localparam int IRQ_W         = 4;
  localparam int IRQ_TRIP_LSB  = 0;
  localparam int IRQ_SHORT_BIT = 2;
  localparam int IRQ_SHUT_BIT  = 3;

  // Reset values
  localparam logic [15:0]      OFF_TIME_RST = 16'h0064;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

  //////////////////////////////////////////////////////////////////////////////
  // Bridge sequencer states
  typedef enum logic [1:0] {
    ST_DRIVE = 2'b00,
    ST_FAST  = 2'b01,
    ST_SLOW  = 2'b10,
    ST_IDLE  = 2'b11
  } bridge_state_e;

endpackage : chopper_pkg

// >>> rtl/bridge_chopper.sv
// Purpose: Fixed off-time chopper sequencer for one full bridge
// Assumes: osc_tick is a one-cycle pulse at the master oscillator rate
// Notes:   Gate outputs are registered from the next state

`timescale 1ns/1ps
`default_nettype none

module bridge_chopper #(
  parameter int CNT_W     = 16,
  parameter int BLANK_CYC = 200
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Control
  input  wire logic             osc_tick,
  input  wire logic             out_en,
  input  wire logic             mixed,
  input  wire logic             phase,
  input  wire logic [CNT_W-1:0] off_ticks,
  input  wire logic [CNT_W-1:0] fd_ticks,
  // Comparators
  input  wire logic             trip,
  input  wire logic             zero_cur,
  // Gates and status
  output logic                  src_a,
  output logic                  snk_a,
  output logic                  src_b,
  output logic                  snk_b,
  output logic                  trip_evt,
  output logic                  off_phase
);

  localparam int BW = $clog2(BLANK_CYC + 1);
  localparam logic [BW-1:0] BLANK_LOAD = BW'(BLANK_CYC);

  chopper_pkg::bridge_state_e state;
  chopper_pkg::bridge_state_e next_state;
  logic [BW-1:0]    blank_cnt;
  logic [CNT_W-1:0] off_cnt;
  logic             sync_off;

  wire blanked   = blank_cnt != '0;
  wire sw_evt    = next_state != state;
  wire sense_hit = !blanked && trip;
  wire fd_done   = off_cnt >= fd_ticks;
  wire off_done  = off_cnt >= off_ticks;
  wire in_off    = next_state == chopper_pkg::ST_FAST ||
                   next_state == chopper_pkg::ST_SLOW;
  wire next_sync_off = in_off && (sync_off || zero_cur);
  wire fwd       = next_state == chopper_pkg::ST_DRIVE;
  wire rev       = next_state == chopper_pkg::ST_FAST && !next_sync_off;
  wire slow_rect = next_state == chopper_pkg::ST_SLOW && !next_sync_off;

  always_comb begin
    next_state = state;
    unique case (state)
      chopper_pkg::ST_IDLE:  if (out_en) next_state = chopper_pkg::ST_DRIVE;
      chopper_pkg::ST_DRIVE: begin
        if (!out_en) next_state = chopper_pkg::ST_IDLE;
        else if (sense_hit)
          next_state = mixed ? chopper_pkg::ST_FAST : chopper_pkg::ST_SLOW;
      end
      chopper_pkg::ST_FAST: begin
        if (!out_en) next_state = chopper_pkg::ST_IDLE;
        else if (fd_done) next_state = chopper_pkg::ST_SLOW;
      end
      chopper_pkg::ST_SLOW: begin
        if (!out_en) next_state = chopper_pkg::ST_IDLE;
        else if (off_done) next_state = chopper_pkg::ST_DRIVE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= chopper_pkg::ST_IDLE;
      blank_cnt <= '0;
      off_cnt   <= '0;
      sync_off  <= 1'b0;
    end else begin
      state     <= next_state;
      blank_cnt <= sw_evt ? BLANK_LOAD : (blanked ? blank_cnt - 1'b1 : '0);
      off_cnt   <= !in_off ? '0 : off_cnt + CNT_W'(osc_tick);
      sync_off  <= next_sync_off;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_a     <= 1'b0;
      snk_a     <= 1'b0;
      src_b     <= 1'b0;
      snk_b     <= 1'b0;
      trip_evt  <= 1'b0;
      off_phase <= 1'b0;
    end else begin
      src_a     <= (fwd && phase) || (rev && !phase);
      snk_b     <= (fwd && phase) || (rev && !phase) || slow_rect;
      src_b     <= (fwd && !phase) || (rev && phase);
      snk_a     <= (fwd && !phase) || (rev && phase) || slow_rect;
      trip_evt  <= state == chopper_pkg::ST_DRIVE && out_en && sense_hit;
      off_phase <= in_off;
    end
  end

  property p_blank_holds;
    @(posedge clk) disable iff (!rst_n)
      (state == chopper_pkg::ST_DRIVE && blanked && out_en)
      |=> state == chopper_pkg::ST_DRIVE;
  endproperty
  a_blank_holds: assert property (p_blank_holds)
    else $error("Comparator honoured during blanking");

  property p_fast_only_mixed;
    @(posedge clk) disable iff (!rst_n)
      (state == chopper_pkg::ST_DRIVE && next_state == chopper_pkg::ST_FAST)
      |-> mixed;
  endproperty
  a_fast_only_mixed: assert property (p_fast_only_mixed)
    else $error("Fast decay entered outside mixed decay");

  property p_reblank;
    @(posedge clk) disable iff (!rst_n)
      (state == chopper_pkg::ST_SLOW && next_state == chopper_pkg::ST_DRIVE)
      |=> blank_cnt == BLANK_LOAD && src_a != src_b;
  endproperty
  a_reblank: assert property (p_reblank)
    else $error("Drive resumed without new blanking");

  property p_zero_stops_rect;
    @(posedge clk) disable iff (!rst_n)
      (zero_cur && in_off) |=> !(src_a || src_b || snk_a || snk_b);
  endproperty
  a_zero_stops_rect: assert property (p_zero_stops_rect)
    else $error("Rectification continued after zero current");

endmodule : bridge_chopper

`default_nettype wire

// >>> rtl/chopper_current_control.sv
// Purpose: Dual-bridge fixed off-time PWM current chopping control
// Assumes: All inputs synchronous to ref_clk; AHB-Lite single word access
// Notes:   Register bus is zero wait state and always answers OKAY
//
// Overview of operation
// - Off-interval counted on 4 MHz oscillator ticks
// - Off-interval length programmable, resistor-derived
// - Grounded timing pin gives 25 us
// - Comparator ignored for 1 us after switching
// - Regulator fault disables all bridge outputs
// - Enable high disables outputs, low enables
// - Translator inputs accepted except in sleep
// - Thermal or pump fault disables, auto-recovers
// - Undervoltage lockout disables and homes translator
// - Mixed decay: fast 30.1 percent, then slow
// - Off-interval switches on decay-mode transistors
// - Zero current stops synchronous rectification
// - Short to ground trips after delay, latched
// - Latched short held until sleep input low
// - Shorted load just chops, never latched
// - Lower DAC level selects mixed, else slow
// - Comparator trip ends drive per decay mode
// - Sleep low disables outputs and homes translator
//
// Implementation choices: the address map and the AHB-Lite slave port.

`timescale 1ns/1ps
`default_nettype none

module chopper_current_control #(
  parameter int DAC_W = 4,
  parameter int NB    = 2
) (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [7:0]          haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic [31:0]              hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  // Device control pins
  input  wire logic                output_enable_n,
  input  wire logic                sleep_reset_n,
  input  wire logic                off_time_resistor_pin_grounded,
  // Analog monitors
  input  wire logic                low_side_gate_regulator_fault,
  input  wire logic                charge_pump_reservoir_low,
  input  wire logic                thermal_shutdown,
  input  wire logic                undervoltage,
  // Translator side
  input  wire logic [NB-1:0]       dac_update,
  input  wire logic [NB*DAC_W-1:0] dac_level,
  input  wire logic [NB-1:0]       phase,
  output logic                     translator_accept,
  output logic                     translator_home,
  // Current sense comparators
  input  wire logic [NB-1:0]       current_sense_trip,
  input  wire logic [NB-1:0]       short_overcurrent_threshold,
  input  wire logic [NB-1:0]       zero_current,
  // Bridge gates
  output logic [NB-1:0]            src_a,
  output logic [NB-1:0]            snk_a,
  output logic [NB-1:0]            src_b,
  output logic [NB-1:0]            snk_b,
  // Interrupt
  output logic                     irq
);

  localparam int OFF_W = chopper_pkg::OFF_W;
  localparam int IW    = chopper_pkg::IRQ_W;
  localparam int SDW   = $clog2(chopper_pkg::SHORT_DLY_CYC + 1);
  localparam logic [SDW-1:0] SHORT_DLY = SDW'(chopper_pkg::SHORT_DLY_CYC);
  localparam logic [chopper_pkg::OSC_DIV_W-1:0] OSC_LAST =
    chopper_pkg::OSC_DIV_W'(chopper_pkg::OSC_DIV - 1);

  //////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic [1:0] rst_sync;
  wire        rst_s_n = rst_sync[1];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Master oscillator tick
  logic [chopper_pkg::OSC_DIV_W-1:0] osc_cnt;
  wire osc_tick = osc_cnt == OSC_LAST;

  always_ff @(posedge ref_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      osc_cnt <= '0;
    end else begin
      osc_cnt <= osc_tick ? '0 : osc_cnt + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Off-interval selection
  logic [OFF_W-1:0] off_time;
  wire [OFF_W-1:0] off_ticks = off_time_resistor_pin_grounded
                             ? OFF_W'(chopper_pkg::OFF_DEFAULT_TICK)
                             : off_time;
  wire [31:0] fd_prod = 32'(off_ticks) * 32'(chopper_pkg::FAST_NUM);
  wire [31:0] fd_quot = fd_prod / 32'(chopper_pkg::FAST_DEN);
  wire [OFF_W-1:0] fd_ticks = fd_quot[OFF_W-1:0];

  //////////////////////////////////////////////////////////////////////////////
  // Faults and output gating
  logic            short_latched;
  logic [SDW-1:0]  short_cnt;
  wire short_any   = |short_overcurrent_threshold;
  wire short_set   = short_any && short_cnt == SHORT_DLY;
  wire shut_fault  = thermal_shutdown || charge_pump_reservoir_low;
  wire out_en      = !output_enable_n && sleep_reset_n && !undervoltage &&
                     !low_side_gate_regulator_fault && !shut_fault &&
                     !short_latched;

  assign translator_accept = sleep_reset_n;
  assign translator_home   = undervoltage || !sleep_reset_n;

  always_ff @(posedge ref_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      short_cnt     <= '0;
      short_latched <= 1'b0;
    end else begin
      short_cnt     <= !short_any ? '0
                     : (short_set ? short_cnt : short_cnt + 1'b1);
      short_latched <= sleep_reset_n && (short_latched || short_set);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decay selection and bridge sequencers
  logic [NB-1:0] mixed;
  logic [NB-1:0] trip_evt;
  logic [NB-1:0] off_phase;

  genvar gi;
  generate
    for (gi = 0; gi < NB; gi++) begin : g_br
      logic [DAC_W-1:0] dac_prev;
      wire  [DAC_W-1:0] dac_new = dac_level[gi*DAC_W +: DAC_W];

      always_ff @(posedge ref_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
          dac_prev    <= '0;
          mixed[gi]   <= 1'b1;
        end else if (translator_home) begin
          dac_prev    <= '0;
          mixed[gi]   <= 1'b1;
        end else if (dac_update[gi]) begin
          dac_prev    <= dac_new;
          mixed[gi]   <= dac_new < dac_prev;
        end
      end

      bridge_chopper #(
        .CNT_W     (OFF_W),
        .BLANK_CYC (chopper_pkg::BLANK_CYC)
      ) u_bridge (
        .clk       (ref_clk),
        .rst_n     (rst_s_n),
        .osc_tick  (osc_tick),
        .out_en    (out_en),
        .mixed     (mixed[gi]),
        .phase     (phase[gi]),
        .off_ticks (off_ticks),
        .fd_ticks  (fd_ticks),
        .trip      (current_sense_trip[gi]),
        .zero_cur  (zero_current[gi]),
        .src_a     (src_a[gi]),
        .snk_a     (snk_a[gi]),
        .src_b     (src_b[gi]),
        .snk_b     (snk_b[gi]),
        .trip_evt  (trip_evt[gi]),
        .off_phase (off_phase[gi])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt events
  logic            shut_prev;
  logic            short_prev;
  logic [IW-1:0]   irq_status;
  logic [IW-1:0]   irq_mask;
  wire  [IW-1:0]   irq_evt;

  assign irq_evt[chopper_pkg::IRQ_TRIP_LSB +: NB]    = trip_evt;
  assign irq_evt[chopper_pkg::IRQ_SHORT_BIT]         = short_latched &&
                                                       !short_prev;
  assign irq_evt[chopper_pkg::IRQ_SHUT_BIT]          = (shut_fault ||
    low_side_gate_regulator_fault) && !shut_prev;
  assign irq = |(irq_status & irq_mask);

  //////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave
  logic       wr_pend;
  logic [7:0] wr_addr;
  wire  addr_ok  = hsel && hready && htrans[1];
  wire  wr_start = addr_ok && hwrite;
  wire  rd_start = addr_ok && !hwrite;
  wire  wr_off   = wr_pend && wr_addr == chopper_pkg::REG_OFF_TIME;
  wire  wr_icl   = wr_pend && wr_addr == chopper_pkg::REG_IRQ_STATUS;
  wire  wr_msk   = wr_pend && wr_addr == chopper_pkg::REG_IRQ_MASK;
  wire  [IW-1:0] irq_clr = wr_icl ? hwdata[IW-1:0] : '0;

  wire [31:0] status_word = {24'h00_0000,
    low_side_gate_regulator_fault, shut_fault, out_en, short_latched,
    off_phase, mixed};
  wire [31:0] rd_mux =
    haddr == chopper_pkg::REG_OFF_TIME   ? {16'h0000, off_time}   :
    haddr == chopper_pkg::REG_STATUS     ? status_word            :
    haddr == chopper_pkg::REG_IRQ_STATUS ? {28'h000_0000, irq_status} :
    haddr == chopper_pkg::REG_IRQ_MASK   ? {28'h000_0000, irq_mask}   :
                                           32'h0000_0000;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge ref_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata  <= 32'h0000_0000;
    end else begin
      wr_pend <= wr_start;
      wr_addr <= wr_start ? haddr : wr_addr;
      hrdata  <= rd_start ? rd_mux : hrdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      off_time   <= chopper_pkg::OFF_TIME_RST;
      irq_mask   <= chopper_pkg::IRQ_MASK_RST;
      irq_status <= '0;
      shut_prev  <= 1'b0;
      short_prev <= 1'b0;
    end else begin
      off_time   <= wr_off ? hwdata[OFF_W-1:0] : off_time;
      irq_mask   <= wr_msk ? hwdata[IW-1:0] : irq_mask;
      irq_status <= (irq_status & ~irq_clr) | irq_evt;
      shut_prev  <= shut_fault || low_side_gate_regulator_fault;
      short_prev <= short_latched;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  wire any_gate = |{src_a, snk_a, src_b, snk_b};

  property p_osc_period;
    @(posedge ref_clk) disable iff (!rst_s_n)
      osc_tick |=> !osc_tick ##49 osc_tick;
  endproperty
  a_osc_period: assert property (p_osc_period)
    else $error("Oscillator tick period is not 50 cycles");

  property p_default_off;
    @(posedge ref_clk) disable iff (!rst_s_n)
      off_time_resistor_pin_grounded |-> off_ticks == OFF_W'(100);
  endproperty
  a_default_off: assert property (p_default_off)
    else $error("Grounded timing pin did not give default off time");

  property p_reg_fault_off;
    @(posedge ref_clk) disable iff (!rst_s_n)
      low_side_gate_regulator_fault |=> !any_gate;
  endproperty
  a_reg_fault_off: assert property (p_reg_fault_off)
    else $error("Outputs on during regulator fault");

  property p_enable_off;
    @(posedge ref_clk) disable iff (!rst_s_n)
      output_enable_n |=> !any_gate;
  endproperty
  a_enable_off: assert property (p_enable_off)
    else $error("Outputs on while enable input high");

  property p_accept_sleep;
    @(posedge ref_clk) disable iff (!rst_s_n)
      translator_accept == sleep_reset_n;
  endproperty
  a_accept_sleep: assert property (p_accept_sleep)
    else $error("Translator acceptance does not follow sleep input");

  property p_shut_off;
    @(posedge ref_clk) disable iff (!rst_s_n)
      shut_fault |=> !any_gate;
  endproperty
  a_shut_off: assert property (p_shut_off)
    else $error("Outputs on during thermal or pump fault");

  property p_uvlo_home;
    @(posedge ref_clk) disable iff (!rst_s_n)
      undervoltage |-> translator_home ##1 !any_gate;
  endproperty
  a_uvlo_home: assert property (p_uvlo_home)
    else $error("Undervoltage did not home and disable");

  property p_short_delay;
    @(posedge ref_clk) disable iff (!rst_s_n)
      $rose(short_latched) |-> $past(short_any) && $past(short_cnt) == SHORT_DLY;
  endproperty
  a_short_delay: assert property (p_short_delay)
    else $error("Short latched without full delay");

  property p_short_hold;
    @(posedge ref_clk) disable iff (!rst_s_n)
      (short_latched && sleep_reset_n) |=> short_latched && !any_gate;
  endproperty
  a_short_hold: assert property (p_short_hold)
    else $error("Latched short released without sleep input");

  property p_decay_select;
    @(posedge ref_clk) disable iff (!rst_s_n)
      (dac_update[0] && !translator_home)
      |=> mixed[0] == ($past(g_br[0].dac_new) < $past(g_br[0].dac_prev));
  endproperty
  a_decay_select: assert property (p_decay_select)
    else $error("Decay mode does not follow DAC direction");

  property p_irq_level;
    @(posedge ref_clk) disable iff (!rst_s_n)
      (irq_evt[chopper_pkg::IRQ_SHORT_BIT] &&
       irq_mask[chopper_pkg::IRQ_SHORT_BIT] && !wr_msk) |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("Unmasked event did not raise interrupt");

endmodule : chopper_current_control

`default_nettype wire

// >>> verification/winding_model.sv
// Purpose: Winding current model behind both bridges
// Assumes: Gate high = on; phase 1 drives src_a with snk_b
// Notes:   Current rises while driven, falls fast on reverse drive
`timescale 1ns/1ps
`default_nettype none
module winding_model (
  // Clock
  input  wire logic       clk,
  // Gates
  input  wire logic [1:0] phase,
  input  wire logic [1:0] src_a,
  input  wire logic [1:0] snk_a,
  input  wire logic [1:0] src_b,
  input  wire logic [1:0] snk_b,
  // Sense
  output logic [1:0]      trip,
  output logic [1:0]      zero
);
  int cur [2] = '{0, 0};
  int tk      = 0;
  logic [1:0] drv;
  logic [1:0] rev;
  assign drv = (phase & src_a & snk_b) | (~phase & src_b & snk_a);
  assign rev = (phase & src_b & snk_a) | (~phase & src_a & snk_b);
  always @(posedge clk) begin
    tk <= tk + 1;
    for (int i = 0; i < 2; i++) begin
      if (drv[i])
        cur[i] <= cur[i] + 1;
      else if (rev[i] && cur[i] > 0)
        cur[i] <= cur[i] - 1;
      else if (cur[i] > 0 && tk % 64 == 0)
        cur[i] <= cur[i] - 1;
    end
  end
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      trip[i] = cur[i] >= 100;
      zero[i] = cur[i] == 0 && !drv[i];
    end
  end
endmodule : winding_model
`default_nettype wire

// >>> verification/testbench.sv
// Purpose: Self-checking bench for the chopper control block
// Assumes: 200 MHz clock, zero wait state register bus
// Notes:   Off spans are measured on the bridge gates
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
  $display("FAIL %0t %h %h", $time, a, b); end end
module testbench;
  logic        ref_clk = 0;
  logic        rst_n = 0;
  logic        hsel = 0;
  logic [7:0]  haddr = 0;
  logic [1:0]  htrans = 0;
  logic        hwrite = 0;
  logic [31:0] hwdata = 0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [4:0]  dis = 5'h01;
  logic        sleep_n = 1;
  logic        gnd = 1;
  logic [1:0]  upd = 0;
  logic [7:0]  lvl = 0;
  logic [1:0]  phase = 2'b01;
  logic [1:0]  trip, zero, src_a, snk_a, src_b, snk_b;
  logic [1:0]  shrt = 0;
  logic        t_acc, t_home, irq;
  logic [31:0] q, lv;
  int          fails = 0, n_tests = 0, cyc = 0, n, seed = 16;
  wire  [3:0]  g0 = {src_a[0], snk_a[0], src_b[0], snk_b[0]};
  wire         any = |{src_a, snk_a, src_b, snk_b};
  always #2.5 ref_clk = ~ref_clk;
  chopper_current_control chopper_current_control_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .output_enable_n(dis[0]), .sleep_reset_n(sleep_n),
    .off_time_resistor_pin_grounded(gnd),
    .low_side_gate_regulator_fault(dis[1]), .thermal_shutdown(dis[2]),
    .charge_pump_reservoir_low(dis[3]), .undervoltage(dis[4]),
    .dac_update(upd), .dac_level(lvl), .phase(phase),
    .translator_accept(t_acc), .translator_home(t_home),
    .current_sense_trip(trip), .short_overcurrent_threshold(shrt),
    .zero_current(zero), .src_a(src_a), .snk_a(snk_a), .src_b(src_b),
    .snk_b(snk_b), .irq(irq));
  winding_model winding_model_i (.clk(ref_clk), .phase(phase),
    .src_a(src_a), .snk_a(snk_a), .src_b(src_b), .snk_b(snk_b),
    .trip(trip), .zero(zero));
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    q = hrdata;
  endtask : ahb
  task automatic span(input logic [3:0] p);
    int k;
    k = 0;
    n = 0;
    while (g0 !== p && k < 20000) begin
      @(posedge ref_clk);
      k++;
    end
    while (g0 === p) begin
      @(posedge ref_clk);
      n++;
    end
  endtask : span
  function automatic logic near(int e);
    return n > e - 60 && n < e + 60;
  endfunction : near
  task automatic complete_run;
    $display("Tests %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      complete_run();
    end
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1;
    repeat (3) @(posedge ref_clk);
    ahb(0, 8'h00, 0); `CHK(q[15:0], 16'h0064)
    `CHK({hresp, hreadyout}, 2'b01)
    ahb(0, 8'h0C, 0); `CHK(q[3:0], 4'h0)
    ahb(0, 8'h10, 0); `CHK(q, 32'h0000_0000)
    lv = $random(seed);
    lvl <= {1'b1, lv[2:0], 1'b1, lv[5:3]};
    upd <= 2'b11;
    @(posedge ref_clk);
    upd <= 0;
    dis <= 0;
    ahb(0, 8'h04, 0); `CHK(q[1:0], 2'b00)
    $display("Registers done");
    span(4'b0101); `CHK(near(100 * 50), 1'b1)
    `CHK(g0, 4'b1001)
    span(4'b1001); `CHK(n >= 200 && n <= 203, 1'b1)
    $display("Slow decay done");
    gnd <= 0;
    ahb(1, 8'h00, 32'h0000_0014);
    lvl <= {1'b1, lv[2:0], 1'b0, lv[8:6]};
    upd <= 2'b01;
    @(posedge ref_clk);
    upd <= 0;
    ahb(0, 8'h04, 0); `CHK(q[1:0], 2'b01)
    span(4'b0110); `CHK(near(20 * 301 / 1000 * 50), 1'b1)
    span(4'b0101); `CHK(near((20 - 20 * 301 / 1000) * 50), 1'b1)
    span(4'b0000); `CHK(n > 0, 1'b1)
    `CHK(g0, 4'b1001)
    $display("Mixed decay done");
    ahb(1, 8'h0C, 32'h0000_0004);
    shrt <= 2'b10;
    repeat (25) @(posedge ref_clk);
    shrt <= 0;
    `CHK({src_a[1], snk_a[1], src_b[1], snk_b[1]}, 4'h0)
    `CHK(irq, 1'b1)
    ahb(1, 8'h08, 32'h0000_0004);
    @(posedge ref_clk);
    `CHK(irq, 1'b0)
    repeat (1000) @(posedge ref_clk);
    ahb(0, 8'h04, 0); `CHK(q[4], 1'b1)
    sleep_n <= 0;
    repeat (3) @(posedge ref_clk);
    `CHK({t_acc, t_home}, 2'b01)
    sleep_n <= 1;
    ahb(0, 8'h04, 0); `CHK(q[4], 1'b0)
    $display("Short done");
    for (int i = 0; i < 5; i++) begin
      dis <= 5'h01 << i;
      repeat (4) @(posedge ref_clk);
      `CHK(any, 1'b0)
      `CHK(t_acc, 1'b1)
      `CHK(t_home, i == 4)
      dis <= 0;
      for (int k = 0; k < 500 && any !== 1'b1; k++) @(posedge ref_clk);
      `CHK(any, 1'b1)
    end
    $display("Shutdown done");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
